//--- hdl/ddc_cfg_pkg.sv
package ddc_cfg_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W = 10;
   localparam int unsigned DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PRESET_SOURCE = 10'h214;
   localparam logic [IDX_W-1:0] IDX_PRESET_SELECT = 10'h215;
   localparam logic [IDX_W-1:0] IDX_CHANNEL_ROUTING = 10'h216;
   localparam logic [IDX_W-1:0] IDX_LINK_CONTROL = 10'h220;
   localparam logic [IDX_W-1:0] IDX_BLOCK_STATUS = 10'h221;

   // Values after reset
   localparam logic [7:0] RST_PRESET_SOURCE = 8'h00;
   localparam logic [7:0] RST_PRESET_SELECT = 8'h00;
   localparam logic [7:0] RST_CHANNEL_ROUTING = 8'h02;
   localparam logic [7:0] RST_LINK_CONTROL = 8'h00;

   // Field positions in preset source and preset select
   localparam int unsigned SRC_LSB = 0;
   localparam int unsigned SEL_A_LSB = 0;
   localparam int unsigned SEL_B_LSB = 2;

   // Field positions in channel routing
   localparam int unsigned ROUTE_A_BIT = 0;
   localparam int unsigned ROUTE_B_BIT = 1;

   // Field positions in link control
   localparam int unsigned CTL_LINK_EN_BIT = 0;
   localparam int unsigned CTL_CAL_EN_BIT = 1;
   localparam int unsigned CTL_PD_A_BIT = 2;
   localparam int unsigned CTL_PD_B_BIT = 3;

   // Field positions in block status
   localparam int unsigned STS_IDX_A_LSB = 0;
   localparam int unsigned STS_IDX_B_LSB = 2;
   localparam int unsigned STS_DIG_PD_A_BIT = 4;
   localparam int unsigned STS_DIG_PD_B_BIT = 5;
   localparam int unsigned STS_PINS_A_LSB = 8;
   localparam int unsigned STS_PINS_B_LSB = 10;

   // Preset storage shape
   localparam int unsigned PRESETS = 4;
   localparam int unsigned SAMPLE_W = 12;
   localparam logic [1:0] PIN_RESET = 2'h0;

   // Where the active preset index comes from
   typedef enum logic [1:0] {
      SRC_REGISTER,
      SRC_PINS_SPLIT,
      SRC_PINS_SHARED,
      SRC_RESERVED
   } preset_source_e;

   // One oscillator preset
   typedef struct packed {
      logic [31:0] osc_freq_word;
      logic [15:0] osc_phase_word;
   } osc_preset_s;

   // One digital channel as handed to the back end
   typedef struct packed {
      logic [SAMPLE_W-1:0] sample;
      logic powerdown;
      logic link_powerdown;
   } dig_channel_s;

endpackage

//--- hdl/preset_pin_sync.sv
`timescale 1ns/1ps
module preset_pin_sync (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Raw pins from the board
   input wire logic [1:0] pins_in,
   // Settled pin value
   output logic [1:0] stable_out
);

   logic [1:0] stage1;
   logic [1:0] stage2;
   logic [1:0] stage3;
   wire settled = (stage2 == stage3);

   // Three-stage chain; whole word moves together so presets never mix
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1 <= ddc_cfg_pkg::PIN_RESET;
         stage2 <= ddc_cfg_pkg::PIN_RESET;
         stage3 <= ddc_cfg_pkg::PIN_RESET;
         stable_out <= ddc_cfg_pkg::PIN_RESET;
      end else begin
         stage1 <= pins_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (settled) begin
            stable_out <= stage3;
         end
      end
   end

   // Settled value only follows after two stages agreed
   property p_settle;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (stable_out != $past(stable_out)) |-> $past(settled);
   endproperty
   a_settle: assert property (p_settle)
      else $error("pin value moved before the chain settled");

endmodule

//--- hdl/ddc_preset_select_and_channel_binding.sv
`timescale 1ns/1ps
// What this block does
// - Source field 0: each converter's preset comes from the select register.
// - Source 1: converter A from its pins, converter B from its own pins.
// - Source 2: converter A pins pick both presets; value 3 is reserved.
// - Four presets per converter, each a frequency and phase word pair.
// - Select bits 3-2 pick converter B's preset when source is 0 or 3.
// - Select bits 1-0 pick converter A's preset when source is 0 or 3.
// - Routing bit 1 feeds digital B from analog A or B; resets to 1.
// - Routing bit 0 feeds digital A from analog A or B; resets to 0.
// - Digital channel and its link power down with their bound analog channel.
// - Preset source and select reset to 0: register source, preset 0.
module ddc_preset_select_and_channel_binding (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Avalon-MM slave
   input wire logic [ddc_cfg_pkg::ADDR_W-1:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [ddc_cfg_pkg::DATA_W-1:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [ddc_cfg_pkg::DATA_W-1:0] readdata_out,
   output logic waitrequest_out,
   // Board preset select pins
   input wire logic [1:0] preset_pins_conv_a_in,
   input wire logic [1:0] preset_pins_conv_b_in,
   // Preset banks held by the oscillator registers
   input wire ddc_cfg_pkg::osc_preset_s [3:0] osc_presets_conv_a_in,
   input wire ddc_cfg_pkg::osc_preset_s [3:0] osc_presets_conv_b_in,
   // Analog channel samples
   input wire logic [ddc_cfg_pkg::SAMPLE_W-1:0] analog_a_sample_in,
   input wire logic [ddc_cfg_pkg::SAMPLE_W-1:0] analog_b_sample_in,
   // Active presets
   output logic [1:0] preset_index_conv_a_out,
   output logic [1:0] preset_index_conv_b_out,
   output ddc_cfg_pkg::osc_preset_s active_preset_conv_a_out,
   output ddc_cfg_pkg::osc_preset_s active_preset_conv_b_out,
   // Digital channels
   output ddc_cfg_pkg::dig_channel_s digital_a_out,
   output ddc_cfg_pkg::dig_channel_s digital_b_out,
   // Control levels for the rest of the back end
   output logic serial_link_enable_out,
   output logic calibration_enable_out
);

   // Register storage
   logic [1:0] preset_source_field;
   logic [3:0] preset_select_reg;
   logic [1:0] channel_routing_reg;
   logic [3:0] link_control;

   // Synchronised pins
   logic [1:0] pins_a_stable;
   logic [1:0] pins_b_stable;

   // Bus decode
   wire [ddc_cfg_pkg::IDX_W-1:0] reg_index =
      address_in[ddc_cfg_pkg::ADDR_W-1:2];
   wire bus_request = read_in | write_in;
   wire accept = bus_request & ~waitrequest_out;
   wire wr_lane0 = write_in & accept & byteenable_in[0];
   wire hit_source = (reg_index == ddc_cfg_pkg::IDX_PRESET_SOURCE);
   wire hit_select = (reg_index == ddc_cfg_pkg::IDX_PRESET_SELECT);
   wire hit_routing = (reg_index == ddc_cfg_pkg::IDX_CHANNEL_ROUTING);
   wire hit_control = (reg_index == ddc_cfg_pkg::IDX_LINK_CONTROL);
   wire hit_status = (reg_index == ddc_cfg_pkg::IDX_BLOCK_STATUS);

   // Named register fields
   wire [1:0] sel_field_a = preset_select_reg[ddc_cfg_pkg::SEL_A_LSB +: 2];
   wire [1:0] sel_field_b = preset_select_reg[ddc_cfg_pkg::SEL_B_LSB +: 2];
   wire route_sel_digital_a = channel_routing_reg[ddc_cfg_pkg::ROUTE_A_BIT];
   wire route_sel_digital_b = channel_routing_reg[ddc_cfg_pkg::ROUTE_B_BIT];
   wire serial_link_enable = link_control[ddc_cfg_pkg::CTL_LINK_EN_BIT];
   wire calibration_enable = link_control[ddc_cfg_pkg::CTL_CAL_EN_BIT];
   wire analog_a_powerdown = link_control[ddc_cfg_pkg::CTL_PD_A_BIT];
   wire analog_b_powerdown = link_control[ddc_cfg_pkg::CTL_PD_B_BIT];
   wire ddc_cfg_pkg::preset_source_e source_mode =
      ddc_cfg_pkg::preset_source_e'(preset_source_field);

   // Pin synchronisers, one per converter
   preset_pin_sync sync_a (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .pins_in(preset_pins_conv_a_in),
      .stable_out(pins_a_stable)
   );

   preset_pin_sync sync_b (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .pins_in(preset_pins_conv_b_in),
      .stable_out(pins_b_stable)
   );

   // Converter A index: register field or its own pins
   wire pins_drive_a = (source_mode == ddc_cfg_pkg::SRC_PINS_SPLIT) |
      (source_mode == ddc_cfg_pkg::SRC_PINS_SHARED);
   wire [1:0] next_index_a = pins_drive_a ? pins_a_stable :
      sel_field_a;

   // Converter B index: field, own pins, or converter A pins
   wire [1:0] next_index_b =
      (source_mode == ddc_cfg_pkg::SRC_PINS_SPLIT) ? pins_b_stable :
      (source_mode == ddc_cfg_pkg::SRC_PINS_SHARED) ? pins_a_stable :
      sel_field_b;

   // Preset bank lookup by active index
   wire ddc_cfg_pkg::osc_preset_s next_preset_a =
      osc_presets_conv_a_in[next_index_a];
   wire ddc_cfg_pkg::osc_preset_s next_preset_b =
      osc_presets_conv_b_in[next_index_b];

   // Sample routing into each digital channel
   wire [ddc_cfg_pkg::SAMPLE_W-1:0] next_sample_a = route_sel_digital_a ?
      analog_b_sample_in : analog_a_sample_in;
   wire [ddc_cfg_pkg::SAMPLE_W-1:0] next_sample_b = route_sel_digital_b ?
      analog_b_sample_in : analog_a_sample_in;

   // Digital power-down follows the bound analog channel
   wire next_dig_pd_a = route_sel_digital_a ?
      analog_b_powerdown : analog_a_powerdown;
   wire next_dig_pd_b = route_sel_digital_b ?
      analog_b_powerdown : analog_a_powerdown;

   // Assembled digital channel words
   wire ddc_cfg_pkg::dig_channel_s next_digital_a = '{
      sample: next_sample_a,
      powerdown: next_dig_pd_a,
      link_powerdown: next_dig_pd_a | ~serial_link_enable
   };
   wire ddc_cfg_pkg::dig_channel_s next_digital_b = '{
      sample: next_sample_b,
      powerdown: next_dig_pd_b,
      link_powerdown: next_dig_pd_b | ~serial_link_enable
   };

   // Status word showing the block's live state
   wire [ddc_cfg_pkg::DATA_W-1:0] status_word =
      (32'(preset_index_conv_a_out) << ddc_cfg_pkg::STS_IDX_A_LSB) |
      (32'(preset_index_conv_b_out) << ddc_cfg_pkg::STS_IDX_B_LSB) |
      (32'(digital_a_out.powerdown) << ddc_cfg_pkg::STS_DIG_PD_A_BIT) |
      (32'(digital_b_out.powerdown) << ddc_cfg_pkg::STS_DIG_PD_B_BIT) |
      (32'(pins_a_stable) << ddc_cfg_pkg::STS_PINS_A_LSB) |
      (32'(pins_b_stable) << ddc_cfg_pkg::STS_PINS_B_LSB);

   // Read mux; reserved bits and unmapped words read zero
   wire [ddc_cfg_pkg::DATA_W-1:0] next_readdata =
      hit_source ? 32'(preset_source_field) :
      hit_select ? 32'(preset_select_reg) :
      hit_routing ? 32'(channel_routing_reg) :
      hit_control ? 32'(link_control) :
      hit_status ? status_word :
      32'h0000_0000;

   // One wait state: answer on the edge after the request is seen
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waitrequest_out <= 1'b1;
         readdata_out <= 32'h0000_0000;
      end else if (bus_request && waitrequest_out) begin
         waitrequest_out <= 1'b0;
         readdata_out <= next_readdata;
      end else begin
         waitrequest_out <= 1'b1;
      end
   end

   // Register writes take effect on the accepting edge
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         preset_source_field <= ddc_cfg_pkg::RST_PRESET_SOURCE[1:0];
         preset_select_reg <= ddc_cfg_pkg::RST_PRESET_SELECT[3:0];
         channel_routing_reg <= ddc_cfg_pkg::RST_CHANNEL_ROUTING[1:0];
         link_control <= ddc_cfg_pkg::RST_LINK_CONTROL[3:0];
      end else if (wr_lane0) begin
         if (hit_source) begin
            preset_source_field <= writedata_in[ddc_cfg_pkg::SRC_LSB +: 2];
         end
         if (hit_select) begin
            preset_select_reg <= writedata_in[3:0];
         end
         if (hit_routing) begin
            // Caller keeps link and calibration off while this changes
            channel_routing_reg <= writedata_in[1:0];
         end
         if (hit_control) begin
            link_control <= writedata_in[3:0];
         end
      end
   end

   // Active preset registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         preset_index_conv_a_out <= 2'h0;
         preset_index_conv_b_out <= 2'h0;
         active_preset_conv_a_out <= '0;
         active_preset_conv_b_out <= '0;
      end else begin
         preset_index_conv_a_out <= next_index_a;
         preset_index_conv_b_out <= next_index_b;
         active_preset_conv_a_out <= next_preset_a;
         active_preset_conv_b_out <= next_preset_b;
      end
   end

   // Digital channel and control output registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         digital_a_out <= '{sample: '0, powerdown: 1'b0, link_powerdown: 1'b1};
         digital_b_out <= '{sample: '0, powerdown: 1'b0, link_powerdown: 1'b1};
         serial_link_enable_out <= 1'b0;
         calibration_enable_out <= 1'b0;
      end else begin
         digital_a_out <= next_digital_a;
         digital_b_out <= next_digital_b;
         serial_link_enable_out <= serial_link_enable;
         calibration_enable_out <= calibration_enable;
      end
   end

   // Marks the first clock after reset release
   logic first_cycle;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first_cycle <= 1'b1;
      end else begin
         first_cycle <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   // Register source drives converter A from the select field
   property p_reg_src_a;
      (preset_source_field == 2'h0) |=>
         (preset_index_conv_a_out == $past(sel_field_a));
   endproperty
   a_reg_src_a: assert property (p_reg_src_a)
      else $error("converter A index does not follow select field");

   // Register source drives converter B from the select field
   property p_reg_src_b;
      (preset_source_field == 2'h0) |=>
         (preset_index_conv_b_out == $past(sel_field_b));
   endproperty
   a_reg_src_b: assert property (p_reg_src_b)
      else $error("converter B index does not follow select field");

   // Split pin source uses each converter's own pins
   property p_split_pins;
      (preset_source_field == 2'h1) |=>
         (preset_index_conv_a_out == $past(pins_a_stable)) &&
         (preset_index_conv_b_out == $past(pins_b_stable));
   endproperty
   a_split_pins: assert property (p_split_pins)
      else $error("split pin source picked wrong preset");

   // Shared pin source gives both converters the A pins
   property p_shared_pins;
      (preset_source_field == 2'h2) |=>
         (preset_index_conv_a_out == $past(pins_a_stable)) &&
         (preset_index_conv_b_out == $past(pins_a_stable));
   endproperty
   a_shared_pins: assert property (p_shared_pins)
      else $error("shared pin source picked wrong preset");

   // Pins do not move converter B's index while the register source is chosen
   property p_pins_ignored;
      (preset_source_field == 2'h0) && $stable(preset_source_field) &&
         $stable(preset_select_reg) |=> $stable(preset_index_conv_b_out);
   endproperty
   a_pins_ignored: assert property (p_pins_ignored)
      else $error("pins moved preset under register source");

   // Active word pairs match the bank entries at the active indexes
   property p_word_pair;
      !first_cycle && $stable(osc_presets_conv_a_in) &&
         $stable(osc_presets_conv_b_in) |->
         (active_preset_conv_a_out ==
         osc_presets_conv_a_in[preset_index_conv_a_out]) &&
         (active_preset_conv_b_out ==
         osc_presets_conv_b_in[preset_index_conv_b_out]);
   endproperty
   a_word_pair: assert property (p_word_pair)
      else $error("active preset words do not match index");

   // Routing bit 1 set feeds digital B from analog B
   property p_route_b;
      route_sel_digital_b ##1 1'b1 |->
         (digital_b_out.sample == $past(analog_b_sample_in));
   endproperty
   a_route_b: assert property (p_route_b)
      else $error("digital B not fed from analog B");

   // Routing bit 0 clear feeds digital A from analog A
   property p_route_a;
      !route_sel_digital_a |=>
         (digital_a_out.sample == $past(analog_a_sample_in));
   endproperty
   a_route_a: assert property (p_route_a)
      else $error("digital A not fed from analog A");

   // Power-down of the bound analog channel reaches digital B and its link
   property p_pd_follow;
      (route_sel_digital_b ? analog_b_powerdown : analog_a_powerdown) |=>
         digital_b_out.powerdown && digital_b_out.link_powerdown;
   endproperty
   a_pd_follow: assert property (p_pd_follow)
      else $error("digital B stayed up with bound analog down");

   // Power-down of the bound analog channel reaches digital A and its link
   property p_pd_follow_a;
      (route_sel_digital_a ? analog_b_powerdown : analog_a_powerdown) |=>
         digital_a_out.powerdown && digital_a_out.link_powerdown;
   endproperty
   a_pd_follow_a: assert property (p_pd_follow_a)
      else $error("digital A stayed up with bound analog down");

   // Routing bit 0 set feeds digital A from analog B
   property p_route_a_cross;
      route_sel_digital_a |=>
         (digital_a_out.sample == $past(analog_b_sample_in));
   endproperty
   a_route_a_cross: assert property (p_route_a_cross)
      else $error("digital A not fed from analog B");

   // After reset the register source and preset 0 are in force
   property p_reset_state;
      first_cycle |-> (preset_source_field == 2'h0) &&
         (preset_select_reg == 4'h0) && (channel_routing_reg == 2'h2) &&
         (preset_index_conv_a_out == 2'h0);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset state is not register source preset 0");

   // A wait state is released for exactly one cycle
   property p_one_wait;
      bus_request && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("bus answer timing broken");

endmodule

//--- tb/host_board_model.sv
`timescale 1ns/1ps
module host_board_model (
   // Clock
   input wire logic mclk_in,
   // Avalon-MM master side
   input wire logic waitrequest_in,
   input wire logic [31:0] readdata_in,
   output logic [11:0] address_out,
   output logic read_out,
   output logic write_out,
   output logic [31:0] writedata_out,
   // Board preset select pins
   output logic [1:0] pins_a_out,
   output logic [1:0] pins_b_out
);
   // Idle bus and pins from time zero
   initial begin
      address_out = 12'h000;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'h00000000;
      pins_a_out = 2'h0;
      pins_b_out = 2'h0;
   end

   // One bus cycle; the request is held until waitrequest is seen low
   // at a rising edge, so a slow slave only stretches the cycle
   task automatic xfer(input logic wr, input logic [9:0] idx,
      input logic [7:0] d, output logic [31:0] q);
      @(posedge mclk_in);
      address_out <= {idx, 2'h0};
      writedata_out <= {24'h000000, d};
      read_out <= ~wr;
      write_out <= wr;
      do begin
         @(posedge mclk_in);
      end while (waitrequest_in !== 1'b0);
      q = readdata_in;
      read_out <= 1'b0;
      write_out <= 1'b0;
   endtask

   // Board moves the select pins right after an edge
   task automatic set_pins(input logic [1:0] a, input logic [1:0] b);
      @(posedge mclk_in);
      pins_a_out <= a;
      pins_b_out <= b;
   endtask
endmodule

//--- tb/test_ddc_preset_select_and_channel_binding.sv
`timescale 1ns/1ps
module test_ddc_preset_select_and_channel_binding;
   localparam logic [9:0] A_SRC = ddc_cfg_pkg::IDX_PRESET_SOURCE;
   localparam logic [9:0] A_SEL = ddc_cfg_pkg::IDX_PRESET_SELECT;
   localparam logic [9:0] A_RTE = ddc_cfg_pkg::IDX_CHANNEL_ROUTING;
   localparam logic [9:0] A_CTL = ddc_cfg_pkg::IDX_LINK_CONTROL;
   localparam logic [9:0] A_STS = ddc_cfg_pkg::IDX_BLOCK_STATUS;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] seed = 32'h00000027;
   int miscompares = 0;
   int n_tests = 0;
   ddc_cfg_pkg::osc_preset_s [3:0] bank_a;
   ddc_cfg_pkg::osc_preset_s [3:0] bank_b;
   logic [11:0] smp_a = 12'h000;
   logic [11:0] smp_b = 12'h000;
   logic [11:0] address;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic wait_req;
   logic [1:0] pins_a;
   logic [1:0] pins_b;
   logic [1:0] idx_a;
   logic [1:0] idx_b;
   ddc_cfg_pkg::osc_preset_s act_a;
   ddc_cfg_pkg::osc_preset_s act_b;
   ddc_cfg_pkg::dig_channel_s dig_a;
   ddc_cfg_pkg::dig_channel_s dig_b;
   logic link_en;
   logic cal_en;

   // Free-running 100 MHz clock
   initial begin
      forever #5 mclk = ~mclk;
   end

   ddc_preset_select_and_channel_binding i_ddc_preset_select_and_channel_binding (
      .mclk_in(mclk), .rst_n_in(rst_n), .address_in(address),
      .read_in(rd), .write_in(wr), .writedata_in(wdata),
      .byteenable_in(4'hF), .readdata_out(rdata),
      .waitrequest_out(wait_req), .preset_pins_conv_a_in(pins_a),
      .preset_pins_conv_b_in(pins_b), .osc_presets_conv_a_in(bank_a),
      .osc_presets_conv_b_in(bank_b), .analog_a_sample_in(smp_a),
      .analog_b_sample_in(smp_b), .preset_index_conv_a_out(idx_a),
      .preset_index_conv_b_out(idx_b), .active_preset_conv_a_out(act_a),
      .active_preset_conv_b_out(act_b), .digital_a_out(dig_a),
      .digital_b_out(dig_b), .serial_link_enable_out(link_en),
      .calibration_enable_out(cal_en));

   host_board_model i_host_board_model (
      .mclk_in(mclk), .waitrequest_in(wait_req), .readdata_in(rdata),
      .address_out(address), .read_out(rd), .write_out(wr),
      .writedata_out(wdata), .pins_a_out(pins_a), .pins_b_out(pins_b));

   // Xorshift source of repeatable random values
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected {index B, index A} from source mode, select and pins
   function automatic logic [3:0] exp_idx(input logic [1:0] m,
      input logic [3:0] s, input logic [1:0] pa, input logic [1:0] pb);
      case (m)
         2'h1: exp_idx = {pb, pa};
         2'h2: exp_idx = {pa, pa};
         default: exp_idx = s;
      endcase
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic done_test(input string name);
      $display("Test %s done: %0d compares, %0d mismatches", name, n_tests,
         miscompares);
   endtask

   task automatic end_of_test();
      $display("Totals: %0d compares, %0d mismatches", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #100000;
      miscompares++;
      end_of_test();
   end

   // Main sequence
   initial begin
      logic [31:0] q;
      logic [31:0] r;
      logic [3:0] sel;
      logic [3:0] e;
      logic [11:0] ea;
      logic [11:0] eb;
      logic pa_d;
      logic pb_d;
      for (int i = 0; i < 4; i++) begin
         bank_a[i] <= 48'({xs(), xs()});
         bank_b[i] <= 48'({xs(), xs()});
      end
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      i_host_board_model.xfer(1'b0, A_SRC, 8'h00, q);
      chk(q, 0);
      i_host_board_model.xfer(1'b0, A_SEL, 8'h00, q);
      chk(q, 0);
      i_host_board_model.xfer(1'b0, A_RTE, 8'h00, q);
      chk(q, 2);
      i_host_board_model.xfer(1'b0, 10'h3FF, 8'h00, q);
      chk(q, 0);
      @(negedge mclk);
      chk({idx_b, idx_a}, 0);
      chk(act_a, bank_a[0]);
      done_test("reset");
      // Source modes 0 to 2 with random select and pins
      for (int m = 0; m < 3; m++) begin
         for (int k = 0; k < 6; k++) begin
            r = xs();
            sel = (k == 0) ? 4'hF : r[3:0];
            i_host_board_model.xfer(1'b1, A_SRC, 8'(m), q);
            i_host_board_model.xfer(1'b1, A_SEL, {r[15:12], sel}, q);
            i_host_board_model.xfer(1'b0, A_SEL, 8'h00, q);
            chk(q, {28'h0, sel});
            i_host_board_model.set_pins(r[5:4], r[7:6]);
            settle(8);
            e = exp_idx(m[1:0], sel, r[5:4], r[7:6]);
            chk({idx_b, idx_a}, e);
            chk(act_a, bank_a[e[1:0]]);
            chk(act_b, bank_b[e[3:2]]);
            i_host_board_model.xfer(1'b0, A_STS, 8'h00, q);
            chk(q, {20'h0, r[7:6], r[5:4], 4'h0, e});
            i_host_board_model.set_pins(~r[5:4], ~r[7:6]);
            settle(2);
            chk({idx_b, idx_a}, e);
         end
         done_test("preset source");
      end
      // Every routing value with random power-down and link enable
      for (int b = 0; b < 4; b++) begin
         r = xs();
         i_host_board_model.xfer(1'b1, A_CTL, 8'h00, q);
         i_host_board_model.xfer(1'b1, A_RTE, 8'(b), q);
         i_host_board_model.xfer(1'b1, A_CTL, {4'h0, r[3:0]}, q);
         @(posedge mclk);
         smp_a <= r[27:16];
         smp_b <= r[15:4];
         settle(4);
         ea = b[0] ? r[15:4] : r[27:16];
         eb = b[1] ? r[15:4] : r[27:16];
         pa_d = b[0] ? r[3] : r[2];
         pb_d = b[1] ? r[3] : r[2];
         chk(dig_a, {ea, pa_d, pa_d | ~r[0]});
         chk(dig_b, {eb, pb_d, pb_d | ~r[0]});
         chk({cal_en, link_en}, r[1:0]);
      end
      i_host_board_model.xfer(1'b1, A_CTL, 8'h00, q);
      i_host_board_model.xfer(1'b1, A_RTE, 8'h02, q);
      i_host_board_model.xfer(1'b0, A_RTE, 8'h00, q);
      chk(q, 2);
      done_test("routing");
      end_of_test();
   end
endmodule
